// ---- btl_unit.sv ----
// Purpose: Jump decision and logical result unit, AHB-Lite slave
// Assumes: Single word transfers, zero wait states
// Notes:   Results are latched at command start; busy covers timing
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
module btl_unit
    import btl_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // =====================================================
    // Helpers
    function automatic logic acc_overlaps_idx(logic [3:0] a, logic [3:0] x);
        acc_overlaps_idx = ({1'b0, x} == ({1'b0, a} + ACC_IDX_OFS));
    endfunction : acc_overlaps_idx

    // =====================================================
    // State
    btl_state_t   state_q, state_d;
    logic [35:0]  opnd_q [4];
    logic [35:0]  opnd_d [4];
    logic [35:0]  res_q, res_d;
    logic [7:0]   proc_state_q, proc_state_d;
    logic [7:0]   cnt_q, cnt_d;
    logic [7:0]   stat_q, stat_d;
    logic [7:0]   addr_q, addr_d;
    logic         wr_q, wr_d;
    logic [31:0]  rdata_d;
    logic         start;
    logic         fn_ok;
    logic         taken;
    logic [17:0]  idx_lo;
    btl_cmd_t     cmd;

    assign cmd = btl_cmd_t'(hwdata[19:0]);

    // =====================================================
    // Next state
    always_comb
    begin
        state_d = state_q;
        opnd_d  = opnd_q;
        res_d   = res_q;
        proc_state_d = proc_state_q;
        cnt_d   = cnt_q;
        stat_d  = stat_q;
        addr_d  = addr_q;
        wr_d    = 1'b0;
        rdata_d = 32'h0000_0000;
        fn_ok   = 1'b0;
        taken   = 1'b0;
        idx_lo  = opnd_q[OPND_IDX][17:0];

        // Address phase
        if (hsel && hready && htrans[1])
        begin
            addr_d = haddr[7:0];
            wr_d   = hwrite;
            if (!hwrite)
            begin
                if (haddr[7:0] <= ADR_OPND_TOP)
                begin
                    if (haddr[2])
                        rdata_d = {28'h000_0000, opnd_q[haddr[4:3]][35:32]};
                    else
                        rdata_d = opnd_q[haddr[4:3]][31:0];
                end
                else
                begin
                    case (haddr[7:0])
                        ADR_RES_LO: rdata_d = res_q[31:0];
                        ADR_RES_HI: rdata_d = {28'h000_0000, res_q[35:32]};
                        ADR_PROC_STATE: rdata_d = {24'h00_0000, proc_state_q};
                        ADR_STAT:   rdata_d = {24'h00_0000, stat_q};
                        default:    rdata_d = 32'h0000_0000;
                    endcase
                end
            end
        end

        // Data phase writes
        start = 1'b0;
        if (wr_q)
        begin
            if (addr_q <= ADR_OPND_TOP)
            begin
                if (addr_q[2])
                    opnd_d[addr_q[4:3]][35:32] = hwdata[3:0];
                else
                    opnd_d[addr_q[4:3]][31:0] = hwdata;
            end
            else if (addr_q == ADR_PROC_STATE)
                proc_state_d = hwdata[7:0];
            else if (addr_q == ADR_CMD && state_q == ST_IDLE)
                start = 1'b1;
        end

        // Command decode and execution
        if (start)
        begin
            stat_d = 8'h00;
            if (cmd.f == F_JUMPS)
            begin
                fn_ok = 1'b1;
                case (cmd.j)
                    J_IDX:
                    begin
                        taken = !idx_lo[17] && (idx_lo != 18'h0_0000);
                        res_d = {opnd_q[OPND_IDX][35:18],
                                 idx_lo + opnd_q[OPND_IDX][35:18]};
                        stat_d[ST_WB_IDX]   = 1'b1;
                        stat_d[ST_IDX_ONCE] = (cmd.a == cmd.x) && cmd.h;
                        stat_d[ST_STATE_SAVE] = !proc_state_q[POS_EXEC_USER] && (cmd.a == 4'h0);
                    end
                    // Designator jumps never look at cmd.a
                    J_OVF:    taken = proc_state_q[POS_OVF_DESIG];
                    J_NOVF:   taken = !proc_state_q[POS_OVF_DESIG];
                    J_CARRY:  taken = proc_state_q[POS_CARRY_DESIG];
                    J_NCARRY: taken = !proc_state_q[POS_CARRY_DESIG];
                    default:  fn_ok = 1'b0;
                endcase
                cnt_d = (taken ? C_LONG : C_SHORT) - 8'h01;
                stat_d[ST_JUMP] = taken;
            end
            else
            begin
                fn_ok = 1'b1;
                // U is taken as already partial-word selected
                case (cmd.f)
                    F_OR:    res_d = opnd_q[OPND_ACC] | opnd_q[OPND_U];
                    F_XOR:   res_d = opnd_q[OPND_ACC] ^ opnd_q[OPND_U];
                    F_AND:   res_d = opnd_q[OPND_ACC] & opnd_q[OPND_U];
                    F_MERGE: res_d = (opnd_q[OPND_U] & opnd_q[OPND_MASK])
                                   | (opnd_q[OPND_ACC] & ~opnd_q[OPND_MASK]);
                    default: fn_ok = 1'b0;
                endcase
                cnt_d = (cmd.same_bank ? C_LONG : C_SHORT) - 8'h01;
                stat_d[ST_WB_ACC] = 1'b1;
                stat_d[ST_UNDEF]  = (cmd.f == F_XOR || cmd.f == F_AND) && cmd.h
                                  && acc_overlaps_idx(cmd.a, cmd.x);
            end
            if (fn_ok)
            begin
                state_d = ST_EXEC;
                stat_d[ST_BUSY] = 1'b1;
            end
            else
            begin
                // Unknown codes are dropped without touching state
                res_d  = res_q;
                cnt_d  = cnt_q;
                stat_d = stat_q;
            end
        end

        case (state_q)
            ST_IDLE: ;
            ST_EXEC:
            begin
                if (cnt_q == 8'h00)
                begin
                    state_d = ST_IDLE;
                    stat_d[ST_BUSY] = 1'b0;
                    stat_d[ST_DONE] = 1'b1;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // =====================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q   <= ST_IDLE;
            for (int i = 0; i < 4; i++)
                opnd_q[i] <= WORD_RST;
            res_q     <= WORD_RST;
            proc_state_q <= PROC_STATE_RST;
            cnt_q     <= 8'h00;
            stat_q    <= 8'h00;
            addr_q    <= 8'h00;
            wr_q      <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            opnd_q    <= opnd_d;
            res_q     <= res_d;
            proc_state_q <= proc_state_d;
            cnt_q     <= cnt_d;
            stat_q    <= stat_d;
            addr_q    <= addr_d;
            wr_q      <= wr_d;
            hrdata    <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // =====================================================
    // Checks
    // Property delays need local int constants, so the counts are repeated here
    localparam int D_LONG  = 150;
    localparam int D_SHORT = 75;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic is_idx;
    logic is_desig;
    logic proc_state_wr;
    assign is_idx   = start && cmd.f == F_JUMPS && cmd.j == J_IDX;
    assign is_desig = start && cmd.f == F_JUMPS && cmd.j >= J_OVF;
    assign proc_state_wr = wr_q && addr_q == ADR_PROC_STATE;

    // Done drops on the edge after start, then rises after the full count
    sequence s_done_long;
        ##1 !stat_q[ST_DONE] ##D_LONG stat_q[ST_DONE];
    endsequence

    sequence s_done_short;
        ##1 !stat_q[ST_DONE] ##D_SHORT stat_q[ST_DONE];
    endsequence

    AST_IDX_TAKEN: assert property (is_idx |=> stat_q[ST_JUMP] ==
        (!$past(idx_lo[17]) && $past(idx_lo) != 18'h0_0000))
        else $error("index jump decision wrong");
    AST_IDX_SUM: assert property (is_idx |=> res_q[17:0] ==
        18'($past(opnd_q[OPND_IDX][17:0]) + $past(opnd_q[OPND_IDX][35:18])))
        else $error("index sum wrong");
    AST_IDX_UPPER: assert property (is_idx |=> res_q[35:18] ==
        $past(opnd_q[OPND_IDX][35:18]))
        else $error("upper half modified");
    AST_OVF_JUMP: assert property (is_desig && cmd.j == J_OVF |=>
        stat_q[ST_JUMP] == $past(proc_state_q[POS_OVF_DESIG]))
        else $error("overflow jump wrong");
    AST_NOVF_JUMP: assert property (is_desig && cmd.j == J_NOVF |=>
        stat_q[ST_JUMP] != $past(proc_state_q[POS_OVF_DESIG]))
        else $error("no-overflow jump wrong");
    AST_CARRY_JUMP: assert property (is_desig && cmd.j == J_CARRY |=>
        stat_q[ST_JUMP] == $past(proc_state_q[POS_CARRY_DESIG]))
        else $error("carry jump wrong");
    AST_NCARRY_JUMP: assert property (is_desig && cmd.j == J_NCARRY |=>
        stat_q[ST_JUMP] != $past(proc_state_q[POS_CARRY_DESIG]))
        else $error("no-carry jump wrong");
    AST_STATE_KEEP: assert property (!proc_state_wr |=> $stable(proc_state_q))
        else $error("designators changed");
    AST_JUMP_TIME: assert property (start && cmd.f == F_JUMPS && taken |->
        s_done_long)
        else $error("taken jump time wrong");
    AST_NEXT_TIME: assert property (start && cmd.f == F_JUMPS && fn_ok && !taken |->
        s_done_short)
        else $error("fall-through time wrong");
    AST_LOGIC_TIME: assert property (start && fn_ok && cmd.f != F_JUMPS && !cmd.same_bank
        |-> s_done_short)
        else $error("logic op time wrong");
    AST_MERGE: assert property (start && cmd.f == F_MERGE |=>
        (res_q & $past(opnd_q[OPND_MASK])) == ($past(opnd_q[OPND_U]) & $past(opnd_q[OPND_MASK])))
        else $error("merge wrong");
    AST_XOR: assert property (start && cmd.f == F_XOR |=>
        (res_q ^ $past(opnd_q[OPND_U])) == $past(opnd_q[OPND_ACC]))
        else $error("xor wrong");
    AST_UNDEF: assert property (start && cmd.f == F_AND && cmd.h && cmd.x == cmd.a + 4'hC
        && cmd.a < 4'h4 |=> stat_q[ST_UNDEF])
        else $error("overlap flag missing");
    AST_NO_UNDEF: assert property (start && fn_ok && !cmd.h |=> !stat_q[ST_UNDEF])
        else $error("overlap flag without increment");
    AST_SAME_TIME: assert property (start && fn_ok && cmd.f != F_JUMPS && cmd.same_bank
        |-> s_done_long)
        else $error("same bank logic op time wrong");
    AST_OR: assert property (start && cmd.f == F_OR |=>
        res_q == ($past(opnd_q[OPND_ACC]) | $past(opnd_q[OPND_U])))
        else $error("or wrong");
    AST_AND: assert property (start && cmd.f == F_AND |=>
        res_q == ($past(opnd_q[OPND_ACC]) & $past(opnd_q[OPND_U])))
        else $error("and wrong");
    AST_IDX_ONCE: assert property (is_idx |=> stat_q[ST_IDX_ONCE] ==
        ($past(cmd.a) == $past(cmd.x) && $past(cmd.h)))
        else $error("index once flag wrong");
    AST_STATE_SAVE: assert property (is_idx |=> stat_q[ST_STATE_SAVE] ==
        (!$past(proc_state_q[POS_EXEC_USER]) && $past(cmd.a) == 4'h0))
        else $error("state save flag wrong");

endmodule : btl_unit

// ---- btl_pkg.sv ----
// Purpose: Constants and types for the branch, test and logic unit
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes:   36-bit words are split into low and high bus words
package btl_pkg;

    // =====================================================
    // Register map
    localparam logic [7:0] ADR_RES_LO = 8'h20;
    localparam logic [7:0] ADR_RES_HI = 8'h24;
    localparam logic [7:0] ADR_PROC_STATE = 8'h28;
    localparam logic [7:0] ADR_CMD    = 8'h2C;
    localparam logic [7:0] ADR_STAT   = 8'h30;
    localparam logic [7:0] ADR_OPND_TOP = 8'h1C;

    // Operand slots, each at base 8*index, high part at +4
    localparam logic [1:0] OPND_U    = 2'h0;
    localparam logic [1:0] OPND_ACC  = 2'h1;
    localparam logic [1:0] OPND_IDX  = 2'h2;
    localparam logic [1:0] OPND_MASK = 2'h3;

    // =====================================================
    // Field positions
    localparam int POS_CARRY_DESIG = 0;
    localparam int POS_OVF_DESIG   = 1;
    localparam int POS_EXEC_USER   = 6;
    localparam int ST_BUSY       = 0;
    localparam int ST_DONE       = 1;
    localparam int ST_JUMP       = 2;
    localparam int ST_WB_ACC     = 3;
    localparam int ST_WB_IDX     = 4;
    localparam int ST_STATE_SAVE = 5;
    localparam int ST_IDX_ONCE   = 6;
    localparam int ST_UNDEF      = 7;

    // =====================================================
    // Reset values
    localparam logic [7:0]  PROC_STATE_RST = 8'h00;
    localparam logic [35:0] WORD_RST = 36'h0_0000_0000;

    // =====================================================
    // Function codes (f, j)
    localparam logic [5:0] F_JUMPS = 6'h3C;
    localparam logic [3:0] J_IDX   = 4'hA;
    localparam logic [3:0] J_OVF   = 4'hC;
    localparam logic [3:0] J_NOVF  = 4'hD;
    localparam logic [3:0] J_CARRY = 4'hE;
    localparam logic [3:0] J_NCARRY = 4'hF;
    localparam logic [5:0] F_OR    = 6'h20;
    localparam logic [5:0] F_XOR   = 6'h21;
    localparam logic [5:0] F_AND   = 6'h22;
    localparam logic [5:0] F_MERGE = 6'h23;

    // Index registers sit at accumulator numbers plus this
    localparam logic [4:0] ACC_IDX_OFS = 5'h0C;

    // =====================================================
    // Timing
    localparam int CLK_NS     = 10;
    localparam int T_LONG_NS  = 1500;
    localparam int T_SHORT_NS = 750;
    localparam logic [7:0] C_LONG  = 8'((T_LONG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_SHORT = 8'((T_SHORT_NS + CLK_NS - 1) / CLK_NS);

    // =====================================================
    // Types
    typedef struct packed {
        logic       same_bank;
        logic       h;
        logic [3:0] x;
        logic [3:0] a;
        logic [3:0] j;
        logic [5:0] f;
    } btl_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } btl_state_t;

endpackage : btl_pkg

// ---- btl_host_model.sv ----
// Purpose: AHB-Lite master standing in for the instruction control side
// Assumes: Single word transfers, one slave whose hreadyout is hready
// Notes:   stall_count counts waits that ran out of cycles
module btl_host_model
    import btl_pkg::*;
(
    // Clock
    input  wire logic        hclk,
    // AHB-Lite master
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic [31:0] hrdata,
    input  wire logic        hready
);
    timeunit 1ns;
    timeprecision 1ps;

    int stall_count = 0;

    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ==========================================================
    // Handshake
    // Bounded so a dead slave cannot hang the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 32)
        begin
            @(posedge hclk);
            n++;
        end
        if (n == 32)
            stall_count++;
    endtask : wait_ready

    task automatic addr_phase(input logic [7:0] adr, input logic wr);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, adr};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
    endtask : addr_phase

    // ==========================================================
    // Transfers
    task automatic bus_write(input logic [7:0] adr, input logic [31:0] dat);
        addr_phase(adr, 1'b1);
        hwdata <= dat;
        wait_ready();
    endtask : bus_write

    task automatic bus_read(input logic [7:0] adr, output logic [31:0] dat);
        addr_phase(adr, 1'b0);
        wait_ready();
        dat = hrdata;
    endtask : bus_read
endmodule : btl_host_model

// ---- branch_test_and_logic_unit_tb.sv ----
// Purpose: Self-checking bench for the branch, test and logic unit
// Assumes: Zero wait slave, status polled over the bus
// Notes:   Poll spacing is three cycles, so timing windows are three wide
module branch_test_and_logic_unit_tb
    import btl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          bad_count = 0;
    int          total_checks = 0;

    always #(CLK_NS / 2) hclk = ~hclk;

    btl_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    btl_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hreadyout));

    // ==========================================================
    // Helpers
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        bad_count += host.stall_count;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    function automatic btl_cmd_t mk(logic [5:0] f, logic [3:0] j, a, x, logic h, sb);
        return '{sb, h, x, a, j, f};
    endfunction : mk

    function automatic logic [7:0] stat(logic jmp, wba, wbi, save, once, undef);
        return {undef, once, save, wbi, wba, jmp, 2'b10};
    endfunction : stat

    task automatic put36(input logic [1:0] slot, input logic [35:0] v);
        host.bus_write({3'h0, slot, 3'h0}, v[31:0]);
        host.bus_write({3'h0, slot, 3'h4}, {28'h0, v[35:32]});
    endtask : put36

    task automatic get_res(output logic [35:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        host.bus_read(ADR_RES_LO, lo);
        host.bus_read(ADR_RES_HI, hi);
        v = {hi[3:0], lo};
    endtask : get_res

    // Start a command, poll until done, judge duration and status
    task automatic run(input btl_cmd_t cmd, input int n, input logic [7:0] st);
        logic [31:0] s;
        longint      t0;
        longint      el;
        int          k;
        host.bus_write(ADR_CMD, {12'h0, cmd});
        t0 = $time;
        s = 32'h0;
        k = 0;
        while (s[ST_DONE] !== 1'b1 && k < 400)
        begin
            host.bus_read(ADR_STAT, s);
            k++;
        end
        if (k == 400)
        begin
            bad_count++;
            wrap_up();
        end
        el = ($time - t0) / CLK_NS;
        check(36'(el >= n + 3 && el <= n + 5), 36'h1);
        check(36'({hreadyout, hresp, s[7:0]}), 36'({2'b10, st}));
    endtask : run

    // ==========================================================
    // Scenarios
    task automatic test_logic();
        logic [35:0] u;
        logic [35:0] acc;
        logic [35:0] m;
        logic [35:0] r;
        logic [35:0] e;
        logic [31:0] s;
        host.bus_read(8'h40, s);
        check(36'(s), 36'h0);
        u   = 36'hC_F0F0_1234;
        acc = 36'h3_0FF0_5678;
        m   = 36'hA_FF00_F0F0;
        put36(OPND_U, u);
        put36(OPND_ACC, acc);
        put36(OPND_MASK, m);
        for (int i = 0; i < 4; i++)
        begin
            e = (i == 0) ? (u | acc) : (i == 1) ? (u ^ acc) : (i == 2) ? (u & acc) : ((u & m) | (acc & ~m));
            run(mk(F_OR + 6'(i), 4'h0, 4'h2, 4'h0, 1'b0, i == 0), (i == 0) ? C_LONG : C_SHORT,
                stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
            get_res(r);
            check(r, e);
        end
        run(mk(F_XOR, 4'h0, 4'h1, 4'hD, 1'b1, 1'b0), C_SHORT, stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        run(mk(F_AND, 4'h0, 4'h3, 4'hF, 1'b1, 1'b1), C_LONG, stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        $display("logic ops finished");
    endtask : test_logic

    task automatic idx_case(input logic [17:0] hi, lo, input logic [3:0] a, x, input logic h, jmp, save, once);
        logic [35:0] r;
        logic [17:0] sum;
        sum = lo + hi;
        put36(OPND_IDX, {hi, lo});
        run(mk(F_JUMPS, J_IDX, a, x, h, 1'b0), jmp ? C_LONG : C_SHORT,
            stat(jmp, 1'b0, 1'b1, save, once, 1'b0));
        get_res(r);
        check(r, {hi, sum});
    endtask : idx_case

    task automatic test_index();
        host.bus_write(ADR_PROC_STATE, 32'h0);
        // Sum turns negative but the old positive half decides
        idx_case(18'h3FFF8, 18'h00005, 4'h0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
        idx_case(18'h00003, 18'h00000, 4'h3, 4'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        idx_case(18'h20000, 18'h20000, 4'h2, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0);
        host.bus_write(ADR_PROC_STATE, 32'h40);
        idx_case(18'h00001, 18'h1FFFF, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("index jump finished");
    endtask : test_index

    task automatic test_desig();
        logic [7:0]  pv [2] = '{8'h42, 8'h01};
        logic [3:0]  js [4] = '{J_OVF, J_NOVF, J_CARRY, J_NCARRY};
        logic        jmp;
        logic [31:0] s;
        for (int p = 0; p < 2; p++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                host.bus_write(ADR_PROC_STATE, {24'h0, pv[p]});
                jmp = (k == 0) ? pv[p][1] : (k == 1) ? !pv[p][1] : (k == 2) ? pv[p][0] : !pv[p][0];
                run(mk(F_JUMPS, js[k], 4'hF, 4'h0, 1'b0, 1'b0), jmp ? C_LONG : C_SHORT,
                    stat(jmp, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
                host.bus_read(ADR_PROC_STATE, s);
                check(36'(s[7:0]), 36'(pv[p]));
            end
        end
        $display("designator jumps finished");
    endtask : test_desig

    // ==========================================================
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        test_logic();
        test_index();
        test_desig();
        wrap_up();
    end
endmodule : branch_test_and_logic_unit_tb
